// ==== include/prtim_cfg.svh ====
// constants of the prescaled interval timer
`ifndef PRTIM_CFG_SVH
`define PRTIM_CFG_SVH
`define PRTIM_COUNT_WIDTH 16
`define PRTIM_SCALE_WIDTH 8
`define PRTIM_INPUT_CLOCK_MHZ 10
`define PRTIM_CYCLE_NS 50
`define PRTIM_CYCLES_PER_INPUT_PERIOD 2
`define PRTIM_COUNT_RESET 16'h0000
`define PRTIM_SCALE_RESET 8'h00
`define PRTIM_PERIOD_RESET 16'h0000
`endif

// ==== include/prtim_pkg.sv ====
// types of the prescaled interval timer
package prtim_pkg;
   typedef logic [15:0] prtim_count_type;
   typedef logic [7:0] prtim_scale_type;
endpackage : prtim_pkg

// ==== rtl/prtim_prescaler.sv ====
// prescaler down-counter issuing one decrement strobe per interval
`timescale 1ns/1ps
`include "prtim_cfg.svh"
module prtim_prescaler (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // control
   input wire logic loadValue,
   input wire prtim_pkg::prtim_scale_type timer_prescale_value,
   // strobe
   output logic tickStrobe
);
   prtim_pkg::prtim_scale_type remaining;

   // reaching zero gives the strobe, so value n-1 spaces strobes n cycles apart
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         remaining <= `PRTIM_SCALE_RESET;
      end else if (loadValue || remaining == 8'h00) begin
         remaining <= timer_prescale_value;
      end else begin
         remaining <= remaining - 8'h01;
      end
   end

   assign tickStrobe = !loadValue && remaining == 8'h00;
endmodule : prtim_prescaler

// ==== rtl/prtim_timer.sv ====
// prescaled interval timer of the processor core
// Summary of operation
// - A 16-bit running count is decremented by one each time the prescaled interval elapses.
// - An 8-bit prescale value holds n minus one, so zero decrements every cycle.
// - A tick that finds the count at zero raises the timer interrupt request toward the core.
// - On that tick the count reloads from a separate 16-bit period value.
// - Counting runs by itself alongside instruction execution.
// - The timer interrupt is a core interrupt source of its own.
// - A processor cycle lasts 50 ns with a 10 MHz input clock, two per input period.
// - The processor cycle is half the input clock period.
`timescale 1ns/1ps
`include "prtim_cfg.svh"
module prtim_timer (
   // processor cycle clock and reset
   input wire logic clock,
   input wire logic resetn,
   // writes from the core
   input wire logic countWrite,
   input wire prtim_pkg::prtim_count_type countWriteData,
   input wire logic scaleWrite,
   input wire prtim_pkg::prtim_scale_type scaleWriteData,
   input wire logic periodWrite,
   input wire prtim_pkg::prtim_count_type periodWriteData,
   // state toward the core
   output prtim_pkg::prtim_count_type timer_running_count,
   output prtim_pkg::prtim_scale_type timer_prescale_value,
   output prtim_pkg::prtim_count_type timer_reload_period,
   // own interrupt source, one-cycle pulse, held steady when scale and period are both zero
   output logic timerInterrupt
);
   // clock is the processor cycle: 20 MHz here, twice the input clock rate
   // doubling of the input clock rate happens upstream, so one clock reaches this block

   // timing at a glance, scale s and period p:
   // a scale write at edge e reloads the prescaler, first tick at edge e+s+1
   // ticks then follow every s+1 edges while scaleWriteData still holds s, as the prescaler reloads from it at zero
   // a tick that finds the count at zero reloads p and raises the interrupt
   // the interrupt stands for the one cycle after that edge
   // interrupts therefore recur every (p+1)*(s+1) cycles
   // a count write at the edge of a tick keeps the written value and drops the tick
   // limitation: a count write of zero raises no interrupt itself; the next tick finds zero and raises it

   // reloaded marks the cycle after a tick found zero
   typedef enum {
      phaseStepping,
      phaseReloaded
   } prtim_phase_type;

   // true when a count sits at its terminal value
   function automatic logic countIsZero(
      input prtim_pkg::prtim_count_type value
   );
      countIsZero = (value == 16'h0000);
   endfunction : countIsZero

   function automatic prtim_pkg::prtim_count_type countStepDown(
      input prtim_pkg::prtim_count_type value
   );
      countStepDown = value - 16'h0001;
   endfunction : countStepDown

   // value after a tick: reload from the period at zero, one lower otherwise
   function automatic prtim_pkg::prtim_count_type countAfterTick(
      input prtim_pkg::prtim_count_type value,
      input prtim_pkg::prtim_count_type period
   );
      if (countIsZero(value)) begin
         countAfterTick = period;
      end else begin
         countAfterTick = countStepDown(value);
      end
   endfunction : countAfterTick

   // a write from the core wins over a tick in the same cycle
   function automatic prtim_pkg::prtim_count_type countAfterEdge(
      input logic write,
      input prtim_pkg::prtim_count_type data,
      input logic tick,
      input prtim_pkg::prtim_count_type value,
      input prtim_pkg::prtim_count_type period
   );
      if (write) begin
         countAfterEdge = data;
      end else if (tick) begin
         countAfterEdge = countAfterTick(value, period);
      end else begin
         countAfterEdge = value;
      end
   endfunction : countAfterEdge

   // load on a write strobe, otherwise keep what is held
   function automatic prtim_pkg::prtim_scale_type scaleAfterWrite(
      input logic write,
      input prtim_pkg::prtim_scale_type data,
      input prtim_pkg::prtim_scale_type held
   );
      if (write) begin
         scaleAfterWrite = data;
      end else begin
         scaleAfterWrite = held;
      end
   endfunction : scaleAfterWrite

   function automatic prtim_pkg::prtim_count_type periodAfterWrite(
      input logic write,
      input prtim_pkg::prtim_count_type data,
      input prtim_pkg::prtim_count_type held
   );
      if (write) begin
         periodAfterWrite = data;
      end else begin
         periodAfterWrite = held;
      end
   endfunction : periodAfterWrite

   // strobe from the prescaler, one cycle wide per elapsed interval
   logic tickStrobe;
   // a tick that no write from the core overrides
   logic countTickTaken;
   // the taken tick finds the count at zero
   logic tickFindsZero;
   // values for the next edge
   prtim_pkg::prtim_scale_type next_scale;
   prtim_pkg::prtim_count_type next_period;
   prtim_pkg::prtim_count_type next_count;
   prtim_phase_type countPhase;
   prtim_phase_type next_phase;

   // scale and period hold until the core writes them
   always_comb begin
      next_scale = scaleAfterWrite(scaleWrite, scaleWriteData, timer_prescale_value);
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         timer_prescale_value <= `PRTIM_SCALE_RESET;
      end else begin
         timer_prescale_value <= next_scale;
      end
   end

   // a new period is used from the next reload on
   always_comb begin
      next_period = periodAfterWrite(periodWrite, periodWriteData, timer_reload_period);
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         timer_reload_period <= `PRTIM_PERIOD_RESET;
      end else begin
         timer_reload_period <= next_period;
      end
   end

   // a new scale restarts the interval so the change takes effect at once
   prtim_prescaler prescaler (
      .clock(clock),
      .resetn(resetn),
      .loadValue(scaleWrite),
      .timer_prescale_value(scaleWriteData),
      .tickStrobe(tickStrobe)
   );

   // the tick is lost when the core writes the count in the same cycle
   always_comb begin
      countTickTaken = tickStrobe && !countWrite;
      tickFindsZero = countTickTaken && countIsZero(timer_running_count);
   end

   // free running, needs no instruction per step
   always_comb begin
      next_count = countAfterEdge(countWrite, countWriteData, countTickTaken,
         timer_running_count, timer_reload_period);
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         timer_running_count <= `PRTIM_COUNT_RESET;
      end else begin
         timer_running_count <= next_count;
      end
   end

   // phase follows the tick: one cycle in reloaded per zero found
   always_comb begin
      case (countPhase)
         phaseStepping: begin
            if (tickFindsZero) begin
               next_phase = phaseReloaded;
            end else begin
               next_phase = phaseStepping;
            end
         end
         phaseReloaded: begin
            if (tickFindsZero) begin
               next_phase = phaseReloaded;
            end else begin
               next_phase = phaseStepping;
            end
         end
         default: begin
            next_phase = phaseStepping;
         end
      endcase
   end

   // reset leaves the phase stepping, so no pulse comes before a tick
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         countPhase <= phaseStepping;
      end else begin
         countPhase <= next_phase;
      end
   end

   // own source line toward the core, apart from serial and software sources
   assign timerInterrupt = (countPhase == phaseReloaded);
endmodule : prtim_timer

// ==== tb/prtim_checker.sv ====
// port assertions of the interval timer
`timescale 1ns/1ps
module prtim_checker (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // writes from the core
   input wire logic countWrite,
   input wire logic [15:0] countWriteData,
   input wire logic scaleWrite,
   input wire logic [7:0] scaleWriteData,
   input wire logic periodWrite,
   input wire logic [15:0] periodWriteData,
   // state toward the core
   input wire logic [15:0] timer_running_count,
   input wire logic [7:0] timer_prescale_value,
   input wire logic [15:0] timer_reload_period,
   input wire logic timerInterrupt
);
   wire [15:0] cnt = timer_running_count;
   wire [7:0] scl = timer_prescale_value;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   cnt_load_a: assert property (countWrite |=> cnt == $past(countWriteData)) else $error("cl");
   per_load_a: assert property (periodWrite |=> timer_reload_period == $past(periodWriteData))
      else $error("pl");
   scl_load_a: assert property (scaleWrite |=> scl == $past(scaleWriteData)) else $error("sl");
   irq_zero_a: assert property (timerInterrupt |-> $past(cnt) == 16'h0000 && !$past(countWrite))
      else $error("iz");
   irq_reload_a: assert property (timerInterrupt && !$past(periodWrite)
      |-> cnt == timer_reload_period) else $error("ir");
   cnt_step_a: assert property (!$past(countWrite) && cnt != $past(cnt)
      |-> cnt == $past(cnt) - 16'h0001 || timerInterrupt) else $error("cs");
   rate_zero_a: assert property (scl == 8'h00 && !$past(scaleWrite) && !$past(countWrite)
      && $past(cnt) != 16'h0000 |-> cnt == $past(cnt) - 16'h0001) else $error("rz");
   irq_gap_a: assert property (timerInterrupt && scl != 8'h00 |=> !timerInterrupt)
      else $error("ig");
   cover property (timerInterrupt);
   cover property (timerInterrupt && scl == 8'hFF);
   cover property (countWrite && cnt == 16'h0000);
endmodule : prtim_checker
bind prtim_timer prtim_checker prtim_checker_i (.*);

// ==== tb/prtim_core_model.sv ====
// core interrupt logic counting timer pulses
`timescale 1ns/1ps
module prtim_core_model (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // timer source line
   input wire logic timerInterrupt,
   // pulses taken so far
   output int irqSeen
);
   always_ff @(posedge clock or negedge resetn) // own source line
      if (!resetn) irqSeen <= 0; else if (timerInterrupt === 1'b1) irqSeen <= irqSeen + 1;
endmodule : prtim_core_model

// ==== tb/prtim_timer_bench.sv ====
// bench of the interval timer
`timescale 1ns/1ps
module prtim_timer_bench;
   logic clock = 0, resetn = 0, countWrite = 0, scaleWrite = 0, periodWrite = 0, timerInterrupt;
   logic [15:0] countWriteData = 0, periodWriteData = 0, timer_running_count, timer_reload_period;
   logic [7:0] scaleWriteData = 0, timer_prescale_value;
   int irqSeen, fails = 0, cmp_count = 0;
   always #20 clock = ~clock;
   prtim_timer prtim_timer_i (.*);
   prtim_core_model prtim_core_model_i (.*);
   task check(string n, logic [15:0] e, logic [15:0] s);
      cmp_count++;
      if (e !== s) begin fails++; $display("mismatch %s expected %h seen %h", n, e, s); end
   endtask : check
   task prog(logic [7:0] s, logic [15:0] p, logic [15:0] c);
      @(negedge clock) {scaleWrite, periodWrite, countWrite} = 3'h7;
      {scaleWriteData, periodWriteData, countWriteData} = {s, p, c};
      @(negedge clock) {scaleWrite, periodWrite, countWrite} = 3'h0;
   endtask : prog
   // window spans whole periods, so the pulse count ignores phase
   task run(logic [7:0] s, logic [15:0] p, int k);
      int b;
      prog(s, p, 16'h0000);
      check("period", p, timer_reload_period);
      check("scale", {8'h00, s}, timer_prescale_value);
      b = irqSeen;
      repeat (k * (p + 1) * (s + 1)) @(negedge clock);
      check("irqs", k, irqSeen - b);
      $display("run %0d %0d done", s, p);
   endtask : run
   task t_start;
      check("count", 16'h0000, timer_running_count);
      prog(8'h00, 16'h0002, 16'h0005);
      repeat (3) @(negedge clock);
      check("count", 16'h0002, timer_running_count);
      $display("t_start done");
   endtask : t_start
   // scale zero ticks every cycle, so every held write after the first meets a tick at zero; the first meets the reloaded 2
   task t_wins;
      int b;
      prog(8'h00, 16'h0002, 16'h0000);
      @(negedge clock) countWrite = 1'b1;
      @(negedge clock) b = irqSeen;
      repeat (10) @(negedge clock);
      check("irqs", 16'h0000, irqSeen - b);
      check("count", 16'h0000, timer_running_count);
      countWrite = 1'b0;
      $display("t_wins done");
   endtask : t_wins
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   initial begin
      repeat (5) @(negedge clock);
      resetn = 1'b1;
      t_start();
      run(8'h00, 16'h0002, 4);
      run(8'h03, 16'h0004, 3);
      run(8'hFF, 16'h0001, 1);
      t_wins();
      summarize();
   end
   initial begin
      #100000 fails++;
      summarize();
   end
endmodule : prtim_timer_bench
